// *** logic/mrw_pkg.sv ***
// Constants shared by the module reset and watchdog logic
package mrw_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned CYC_PER_MS       = CLK_MHZ * 1000;
  // Normal timeout, typical figure inside the 70..140 ms window
  localparam int unsigned NORMAL_TIMEOUT_MS = 100;
  localparam int unsigned NORMAL_MIN_MS     = 70;
  localparam int unsigned NORMAL_MAX_MS     = 140;
  // First timeout after reset, typical figure inside 1..2.25 s
  localparam int unsigned FIRST_TIMEOUT_MS  = 1600;
  localparam int unsigned FIRST_MIN_MS      = 1000;
  localparam int unsigned FIRST_MAX_MS      = 2250;
  localparam int unsigned NORMAL_TIMEOUT_CYC = NORMAL_TIMEOUT_MS * CYC_PER_MS;
  localparam int unsigned FIRST_TIMEOUT_CYC  = FIRST_TIMEOUT_MS * CYC_PER_MS;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int unsigned CNT_W      = 32;
  localparam int unsigned NUM_CS     = 3;
  localparam int unsigned HOLD_W     = 5;
  localparam logic [HOLD_W-1:0] RST_HOLD_CYC = 5'h10;
  localparam logic [NUM_CS-1:0] CS_IDLE_N    = 3'h7;

  // ==========================================================================
  // Controller states
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_HOLD  = 2'h1,
    ST_ARMED = 2'h2
  } mrw_state_t;

endpackage

// *** logic/mrw_tmr_if.sv ***
// Carrier between the reset controller and the watchdog timer
`timescale 1ns/1ps
`default_nettype none

interface mrw_tmr_if;
  logic load_first;
  logic load_normal;
  logic run;
  logic expired;

  modport ctrl (output load_first, output load_normal, output run, input expired);
  modport tmr  (input load_first, input load_normal, input run, output expired);
endinterface

`default_nettype wire

// *** logic/mrw_timer.sv ***
// Down-counting watchdog timer with first and normal reload values
`timescale 1ns/1ps
`default_nettype none

module mrw_timer #(
  parameter logic [31:0] FIRST_CYC  = 32'h1312D000,
  parameter logic [31:0] NORMAL_CYC = 32'h01312D00
) (
  input wire logic clk,
  input wire logic rst_n,
  mrw_tmr_if.tmr   tif
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        expired;
  } mrw_tmr_state_t;

  mrw_tmr_state_t st_ff;
  mrw_tmr_state_t nxt_st;

  // ==========================================================================
  // Count logic
  // ==========================================================================
  always_comb begin
    nxt_st = st_ff;
    if (tif.load_first) begin
      nxt_st.cnt = FIRST_CYC;
    end else if (tif.load_normal) begin
      nxt_st.cnt = NORMAL_CYC;
    end else if (tif.run && st_ff.cnt != 32'h0) begin
      nxt_st.cnt = st_ff.cnt - 32'h1;
    end
    nxt_st.expired = tif.run && !tif.load_first && !tif.load_normal && st_ff.cnt == 32'h0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{cnt: 32'h0, expired: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tif.expired = st_ff.expired;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_count_down: assert property (@(posedge clk) disable iff (!rst_n)
    tif.run && !tif.load_first && !tif.load_normal && st_ff.cnt != 32'h0 |=> st_ff.cnt == $past(st_ff.cnt) - 32'h1)
    else $error("Timer did not count down");
  a_normal_reload: assert property (@(posedge clk) disable iff (!rst_n)
    tif.load_normal && !tif.load_first |=> st_ff.cnt == NORMAL_CYC && !st_ff.expired)
    else $error("Timer not reloaded with normal value");
  a_first_reload: assert property (@(posedge clk) disable iff (!rst_n)
    tif.load_first |=> st_ff.cnt == FIRST_CYC)
    else $error("Timer not loaded with first value");
  a_zero_expires: assert property (@(posedge clk) disable iff (!rst_n)
    tif.run && !tif.load_first && !tif.load_normal && st_ff.cnt == 32'h0 |=> st_ff.expired)
    else $error("Timer at zero did not expire");

endmodule

`default_nettype wire

// *** logic/mrw_top.sv ***
// Module reset controller: external watchdog and supply-fail supervisor
//
// Summary of operation
// - The watchdog counts down from a preset value and resets the whole module when it reaches zero.
// - Each level change of the kick line reloads the timer; the normal timeout is 100 ms, within 70 to 140 ms.
// - Right after any reset the first timeout is 1.6 s, within 1 to 2.25 s, then the normal period applies.
// - Leaving the kick line undriven disables the watchdog, which then issues no reset.
// - An active supply-fail indication drives a controlled reset of the whole module.
// - During supply failure the SRAM goes to battery backup and its chip selects are gated off.
`timescale 1ns/1ps
`default_nettype none

module mrw_top #(
  parameter int unsigned FIRST_CYC  = mrw_pkg::FIRST_TIMEOUT_CYC,
  parameter int unsigned NORMAL_CYC = mrw_pkg::NORMAL_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RESETN,
  // Watchdog kick line from the processor
  input  wire logic                      WATCHDOG_KICK_LINE,
  input  wire logic                      WATCHDOG_KICK_DRIVEN,
  // Supply supervisor
  input  wire logic                      SUPPLY_FAIL,
  // SRAM select path
  input  wire logic [mrw_pkg::NUM_CS-1:0] CPU_SRAM_CS_N,
  output var  logic [mrw_pkg::NUM_CS-1:0] SRAM_CS_N,
  output var  logic                      SRAM_BATT_SEL,
  // Module reset
  output var  logic                      MODULE_RESET_OUT_N
);

  typedef struct packed {
    logic [1:0]                    kick_sync;
    logic [1:0]                    drv_sync;
    logic [1:0]                    fail_sync;
    logic [2*mrw_pkg::NUM_CS-1:0]  cs_sync;
    logic                          kick_prev;
    mrw_pkg::mrw_state_t           state;
    logic [mrw_pkg::HOLD_W-1:0]    hold_cnt;
    logic                          rst_out_n;
    logic                          batt_sel;
    logic [mrw_pkg::NUM_CS-1:0]    cs_out_n;
  } mrw_top_state_t;

  logic [1:0]     rst_sync_ff;
  logic           rst_n;
  mrw_top_state_t st_ff;
  mrw_top_state_t nxt_st;
  mrw_tmr_if      tif ();

  // Synchronised pin levels, second stage only
  logic                       kick_s;
  logic                       drv_s;
  logic                       fail_s;
  logic [mrw_pkg::NUM_CS-1:0] cs_s;
  logic                       kick_edge;
  logic                       hold_done;

  // ==========================================================================
  // Reset synchroniser
  // ==========================================================================
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ==========================================================================
  // Control logic
  // ==========================================================================
  assign kick_s    = st_ff.kick_sync[1];
  assign drv_s     = st_ff.drv_sync[1];
  assign fail_s    = st_ff.fail_sync[1];
  assign cs_s      = st_ff.cs_sync[2*mrw_pkg::NUM_CS-1:mrw_pkg::NUM_CS];
  assign kick_edge = kick_s != st_ff.kick_prev;
  assign hold_done = st_ff.hold_cnt == '0;

  always_comb begin
    nxt_st = st_ff;
    tif.load_first  = 1'b0;
    tif.load_normal = 1'b0;
    tif.run         = 1'b0;
    nxt_st.kick_sync = {st_ff.kick_sync[0], WATCHDOG_KICK_LINE};
    nxt_st.drv_sync  = {st_ff.drv_sync[0], WATCHDOG_KICK_DRIVEN};
    nxt_st.fail_sync = {st_ff.fail_sync[0], SUPPLY_FAIL};
    nxt_st.cs_sync   = {st_ff.cs_sync[mrw_pkg::NUM_CS-1:0], CPU_SRAM_CS_N};
    nxt_st.kick_prev = kick_s;
    case (st_ff.state)
      mrw_pkg::ST_HOLD: begin
        nxt_st.rst_out_n = 1'b0;
        if (fail_s) begin
          nxt_st.hold_cnt = mrw_pkg::RST_HOLD_CYC;
        end else if (hold_done) begin
          nxt_st.state     = mrw_pkg::ST_ARMED;
          nxt_st.rst_out_n = 1'b1;
          tif.load_first   = 1'b1;
        end else begin
          nxt_st.hold_cnt = st_ff.hold_cnt - 5'h1;
        end
      end
      mrw_pkg::ST_ARMED: begin
        if (fail_s) begin
          nxt_st.state     = mrw_pkg::ST_HOLD;
          nxt_st.rst_out_n = 1'b0;
          nxt_st.hold_cnt  = mrw_pkg::RST_HOLD_CYC;
        end else if (!drv_s) begin
          tif.load_normal = 1'b1;
        end else if (tif.expired) begin
          nxt_st.state     = mrw_pkg::ST_HOLD;
          nxt_st.rst_out_n = 1'b0;
          nxt_st.hold_cnt  = mrw_pkg::RST_HOLD_CYC;
        end else if (kick_edge) begin
          tif.load_normal = 1'b1;
        end else begin
          tif.run = 1'b1;
        end
      end
      default: begin
        nxt_st.state     = mrw_pkg::ST_HOLD;
        nxt_st.rst_out_n = 1'b0;
        nxt_st.hold_cnt  = mrw_pkg::RST_HOLD_CYC;
      end
    endcase
    // Battery backup and chip select gating follow the supply state
    nxt_st.batt_sel = fail_s;
    nxt_st.cs_out_n = fail_s ? mrw_pkg::CS_IDLE_N : cs_s;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{kick_sync: 2'h0, drv_sync: 2'h0, fail_sync: 2'h0, cs_sync: 6'h3F, kick_prev: 1'b0,
                 state: mrw_pkg::ST_HOLD, hold_cnt: mrw_pkg::RST_HOLD_CYC, rst_out_n: 1'b0,
                 batt_sel: 1'b0, cs_out_n: mrw_pkg::CS_IDLE_N};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Watchdog timer
  // ==========================================================================
  mrw_timer #(
    .FIRST_CYC  (FIRST_CYC[31:0]),
    .NORMAL_CYC (NORMAL_CYC[31:0])
  ) u_timer (
    .clk   (CLK),
    .rst_n (rst_n),
    .tif   (tif.tmr)
  );

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign MODULE_RESET_OUT_N = st_ff.rst_out_n;
  assign SRAM_BATT_SEL      = st_ff.batt_sel;
  assign SRAM_CS_N          = st_ff.cs_out_n;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!rst_n);

  a_expiry_resets: assert property (
    st_ff.state == mrw_pkg::ST_ARMED && !fail_s && drv_s && tif.expired |=> !MODULE_RESET_OUT_N)
    else $error("Expired watchdog did not reset the module");
  a_kick_reloads: assert property (
    st_ff.state == mrw_pkg::ST_ARMED && !fail_s && drv_s && !tif.expired && kick_edge |-> tif.load_normal)
    else $error("Kick edge did not reload the timer");
  a_undriven_no_reset: assert property (
    st_ff.state == mrw_pkg::ST_ARMED && !fail_s && !drv_s |=> MODULE_RESET_OUT_N)
    else $error("Reset issued while kick line undriven");
  a_fail_resets: assert property (
    fail_s |=> !MODULE_RESET_OUT_N ##1 !MODULE_RESET_OUT_N)
    else $error("Supply fail did not reset the module");
  a_fail_gates_cs: assert property (
    fail_s |=> SRAM_CS_N == mrw_pkg::CS_IDLE_N && SRAM_BATT_SEL)
    else $error("SRAM not protected during supply fail");
  a_cs_passes: assert property (
    !fail_s |=> SRAM_CS_N == $past(cs_s) && !SRAM_BATT_SEL)
    else $error("Chip selects not passed while supply good");
  a_release_first: assert property (
    $rose(MODULE_RESET_OUT_N) |-> $past(tif.load_first))
    else $error("Release without first timeout load");
  a_hold_length: assert property (
    $fell(MODULE_RESET_OUT_N) |-> !MODULE_RESET_OUT_N [*8])
    else $error("Module reset pulse too short");
  a_first_after_reset: assert property (
    tif.load_first |-> st_ff.state == mrw_pkg::ST_HOLD && !fail_s && hold_done)
    else $error("First timeout loaded outside release");
  a_armed_released: assert property (
    st_ff.state == mrw_pkg::ST_ARMED |-> MODULE_RESET_OUT_N)
    else $error("Module reset low while armed");
  a_hold_asserted: assert property (
    st_ff.state == mrw_pkg::ST_HOLD |-> !MODULE_RESET_OUT_N)
    else $error("Module reset released while holding");
  a_hold_countdown: assert property (
    st_ff.state == mrw_pkg::ST_HOLD && !fail_s && !hold_done |=> st_ff.hold_cnt == $past(st_ff.hold_cnt) - 5'h1)
    else $error("Reset hold counter did not count down");
  a_fail_restarts: assert property (
    st_ff.state == mrw_pkg::ST_HOLD && fail_s |=> st_ff.hold_cnt == mrw_pkg::RST_HOLD_CYC)
    else $error("Supply fail did not restart the reset hold");
  a_undriven_reload: assert property (
    st_ff.state == mrw_pkg::ST_ARMED && !fail_s && !drv_s |-> tif.load_normal && !tif.run)
    else $error("Undriven kick line did not hold the timer");

  c_wd_reset:   cover property (st_ff.state == mrw_pkg::ST_ARMED && drv_s && tif.expired ##1 !MODULE_RESET_OUT_N);
  c_fail_reset: cover property ($rose(fail_s) ##1 !MODULE_RESET_OUT_N);
  c_kick:       cover property (tif.load_normal && drv_s ##1 tif.run);
  c_release:    cover property ($rose(MODULE_RESET_OUT_N));
  c_disabled:   cover property (st_ff.state == mrw_pkg::ST_ARMED && !drv_s ##1 tif.load_normal);

endmodule

`default_nettype wire

// *** bench/mrw_cpu_model.sv ***
// Processor model driving the watchdog kick line
`timescale 1ns/1ps
`default_nettype none

module mrw_cpu_model (
  // Clock
  input  wire logic        clk,
  // Commands from the bench
  input  wire logic        drive_en,
  input  wire logic [15:0] period,
  // Kick pin
  output var  logic        kick,
  output var  logic        driven
);
  logic [15:0] cnt;

  initial begin
    kick   = 1'b0;
    driven = 1'b0;
    cnt    = 16'h0000;
  end

  // ==========================================================================
  // Pin behaviour
  // ==========================================================================
  always @(negedge clk) begin
    driven <= drive_en;
    if (!drive_en) begin
      kick <= ~kick; // Released pin shows a changing pattern
      cnt  <= 16'h0000;
    end else if (period != 16'h0000 && cnt >= period - 16'h0001) begin
      kick <= ~kick; // Toggle inside the normal timeout
      cnt  <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule

`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking testbench for the module reset controller
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int FIRST  = 200;
  localparam int NORMAL = 50;
  logic                        CLK = 1'b0;
  logic                        RESETN = 1'b0;
  logic                        SUPPLY_FAIL = 1'b0;
  logic [mrw_pkg::NUM_CS-1:0]  CPU_SRAM_CS_N = 3'h7;
  logic [mrw_pkg::NUM_CS-1:0]  SRAM_CS_N;
  logic                        SRAM_BATT_SEL;
  logic                        MODULE_RESET_OUT_N;
  logic                        kick;
  logic                        driven;
  logic                        drive_en = 1'b1;
  logic [15:0]                 period = 16'h0000;
  int                          n_mismatch = 0;
  int                          n_compared = 0;
  int                          n;

  always #2.5 CLK = ~CLK;

  mrw_top #(.FIRST_CYC(FIRST), .NORMAL_CYC(NORMAL)) i_mrw_top (
    .CLK(CLK), .RESETN(RESETN), .WATCHDOG_KICK_LINE(kick), .WATCHDOG_KICK_DRIVEN(driven),
    .SUPPLY_FAIL(SUPPLY_FAIL), .CPU_SRAM_CS_N(CPU_SRAM_CS_N), .SRAM_CS_N(SRAM_CS_N),
    .SRAM_BATT_SEL(SRAM_BATT_SEL), .MODULE_RESET_OUT_N(MODULE_RESET_OUT_N));

  mrw_cpu_model i_mrw_cpu_model (
    .clk(CLK), .drive_en(drive_en), .period(period), .kick(kick), .driven(driven));

  // ==========================================================================
  // Compare and wait helpers
  // ==========================================================================
  task automatic chk1(input logic exp, input logic got, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic chk3(input logic [2:0] exp, input logic [2:0] got, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic chk_rng(input int v, input int lo, input int hi, input string msg);
    n_compared++;
    if (v < lo || v > hi) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: %0d", $time, msg, v);
    end
  endtask

  task automatic wait_rst(input logic lvl, input int max, output int cnt);
    cnt = 0;
    while (MODULE_RESET_OUT_N !== lvl && cnt < max) begin
      @(posedge CLK);
      #1;
      cnt++;
    end
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    repeat (5) @(negedge CLK);
    chk1(1'b0, MODULE_RESET_OUT_N, "reset out not low in reset");
    chk3(3'h7, SRAM_CS_N, "chip selects not idle in reset");
    RESETN = 1'b1;
    wait_rst(1'b1, 40, n);
    chk_rng(n, 16, 22, "reset release time");
    $display("test reset done");
  endtask

  task automatic t_first();
    drive_en = 1'b1;
    wait_rst(1'b0, FIRST + 20, n);
    chk_rng(n, FIRST, FIRST + 4, "first timeout length");
    wait_rst(1'b1, 40, n);
    chk_rng(n, 16, 18, "module reset pulse length");
    $display("test first timeout done");
  endtask

  task automatic t_kick();
    @(negedge CLK);
    period <= 16'h0028;
    wait_rst(1'b0, 600, n);
    chk_rng(n, 600, 600, "reset despite regular kicks");
    @(kick);
    period <= 16'h0000;
    wait_rst(1'b0, NORMAL + 20, n);
    chk_rng(n, NORMAL + 2, NORMAL + 8, "normal timeout length");
    wait_rst(1'b1, 40, n);
    chk_rng(n, 16, 18, "reset pulse after normal timeout");
    $display("test kick done");
  endtask

  task automatic t_disabled();
    @(negedge CLK);
    drive_en <= 1'b0;
    wait_rst(1'b0, 600, n);
    chk_rng(n, 600, 600, "reset while watchdog disabled");
    @(negedge CLK);
    drive_en <= 1'b1;
    wait_rst(1'b0, FIRST, n);
    chk_rng(n, NORMAL, NORMAL + 8, "period after re-enable");
    wait_rst(1'b1, 40, n);
    chk_rng(n, 16, 18, "reset pulse after re-enable");
    $display("test disabled done");
  endtask

  task automatic t_fail();
    @(negedge CLK);
    period        <= 16'h0014;
    CPU_SRAM_CS_N = 3'h5;
    repeat (4) @(negedge CLK);
    chk3(3'h5, SRAM_CS_N, "chip selects not passed through");
    SUPPLY_FAIL   = 1'b1;
    CPU_SRAM_CS_N = 3'h0;
    repeat (4) @(negedge CLK);
    repeat (30) begin
      chk1(1'b0, MODULE_RESET_OUT_N, "no reset on supply fail");
      chk1(1'b1, SRAM_BATT_SEL, "no battery select on fail");
      chk3(3'h7, SRAM_CS_N, "chip selects not gated on fail");
      @(negedge CLK);
    end
    SUPPLY_FAIL = 1'b0;
    period      <= 16'h0000;
    repeat (5) @(negedge CLK);
    chk1(1'b0, SRAM_BATT_SEL, "battery select stuck");
    chk3(3'h0, SRAM_CS_N, "chip selects not restored");
    wait_rst(1'b1, 40, n);
    chk_rng(n, 10, 20, "reset release after fail");
    wait_rst(1'b0, FIRST + 20, n);
    chk_rng(n, FIRST, FIRST + 4, "first timeout after supply fail");
    $display("test supply fail done");
  endtask

  // ==========================================================================
  // Run control
  // ==========================================================================
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge CLK);
    n_mismatch++;
    test_done();
  end

  initial begin
    t_reset();
    t_first();
    t_kick();
    t_disabled();
    t_fail();
    test_done();
  end
endmodule

`default_nettype wire
